/* pxa_pkg.sv */
// Constants shared by the proximity front-end control block.
// Assumes a 32-bit APB slave and a 100 MHz system clock.
package pxa_pkg;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] PXA_OFF_SWC = 8'h00; // Switches 16..23
	localparam logic [7:0] PXA_OFF_SWD = 8'h04; // Switches 24..31
	localparam logic [7:0] PXA_OFF_SWE = 8'h08; // Switches 32..39
	localparam logic [7:0] PXA_OFF_CTRL = 8'h0c; // Front-end control
	localparam logic [7:0] PXA_OFF_STAT = 8'h10; // Sticky status, read clears
	localparam logic [7:0] PXA_OFF_MASK = 8'h14; // Interrupt mask
	localparam logic [7:0] PXA_OFF_LIVE = 8'h18; // Live comparator levels

	// ==========================================================
	// Reset values
	localparam logic [7:0] PXA_RST_BYTE = 8'h00; // All registers clear
	localparam logic [1:0] PXA_RST_EV = 2'h0; // Status and mask clear

	// ==========================================================
	// Control register field positions
	localparam int PXA_CTL_AMP1 = 7; // Second amplifier enable
	localparam int PXA_CTL_AMP0 = 6; // First amplifier enable
	localparam int PXA_CTL_CMP = 5; // Comparator and DAC enable
	localparam int PXA_CTL_EDGE_HI = 4; // Edge select high bit
	localparam int PXA_CTL_EDGE_LO = 3; // Edge select low bit
	localparam int PXA_CTL_DEB_HI = 2; // Debounce select high bit
	localparam int PXA_CTL_DEB_LO = 0; // Debounce select low bit

	// Status bit positions
	localparam int PXA_ST_RISE = 0; // Filtered rising edge seen
	localparam int PXA_ST_FALL = 1; // Filtered falling edge seen

	// ==========================================================
	// Edge select codes
	typedef enum logic [1:0] {
		PXA_EDGE_NONE = 2'h0,
		PXA_EDGE_RISE = 2'h1,
		PXA_EDGE_FALL = 2'h2,
		PXA_EDGE_BOTH = 2'h3
	} pxa_edge_t;

	// Debounce code meaning bypass
	localparam logic [2:0] PXA_DEB_BYPASS = 3'h0;
	// Stable-count width; longest code needs 128 periods
	localparam int PXA_DEB_W = 8;
	localparam logic [7:0] PXA_DEB_ONE = 8'h01;

	// APB data width
	localparam int PXA_DW = 32;

endpackage

/* pxa_ctrl.sv */
// Control registers of the proximity sensing front end: switch banks,
// amplifier, comparator and DAC enables, debounce filter and edge irq.
// Assumes an APB master on sys_clk_in and a raw comparator level that is
// already synchronous to that clock.
`timescale 1ns/1ps

// What this block does
// - Switch bank C bits drive switches 16-23
// - Switch bank D bits drive switches 24-31
// - Switch bank E bits drive switches 32-39
// - Bit 7 low disables amp1, output Hi-Z
// - Bit 6 low disables amp0, output Hi-Z
// - Bit 5 enables comparator/DAC; off forces low
// - Bits 4:3 pick none/rise/fall/both edges
// - Edges detected on debounced comparator only
// - Selected filtered edge raises proximity interrupt
module pxa_ctrl (
	input wire logic sys_clk_in, // System clock, 100 MHz
	input wire logic nrst_in, // Synchronous reset, active low
	input wire logic psel_in, // APB select
	input wire logic penable_in, // APB access phase
	input wire logic pwrite_in, // APB direction, high writes
	input wire logic [7:0] paddr_in, // APB byte address
	input wire logic [pxa_pkg::PXA_DW-1:0] pwdata_in, // APB write data
	input wire logic [3:0] pstrb_in, // APB byte strobes
	input wire logic comparator_raw_out_in, // Raw comparator level
	output logic [pxa_pkg::PXA_DW-1:0] prdata_out, // APB read data
	output logic pready_out, // APB ready
	output logic pslverr_out, // APB error on unmapped address
	output logic [23:0] analog_switch_bits_out, // Switches 16..39
	output logic amp1_enable_out, // Second amplifier on
	output logic amp1_output_pin_oe_out, // Amp1 pin driven
	output logic amp0_enable_out, // First amplifier on
	output logic amp0_output_pin_oe_out, // Amp0 pin driven
	output logic comparator_dac_enable_out, // Comparator and DAC on
	output logic reference_dac_output_oe_out, // DAC pin driven
	output logic comparator_filtered_out, // Debounced comparator
	output logic proximity_interrupt_out // Level interrupt
);
	import pxa_pkg::*;

	// ==========================================================
	// Declarations
	logic [7:0] sw_c_q; // Switch bank C
	logic [7:0] sw_d_q; // Switch bank D
	logic [7:0] sw_e_q; // Switch bank E
	logic [7:0] ctrl_q; // Front-end control
	logic [1:0] stat_q; // Sticky edge status
	logic [1:0] mask_q; // Interrupt mask
	logic [PXA_DEB_W-1:0] deb_cnt_q; // Stable-level counter
	logic [PXA_DEB_W-1:0] deb_len; // Periods required for code
	logic cmp_gated; // Comparator after enable gating
	logic filt_q; // Filtered level
	logic filt_d; // Next filtered level
	logic filt_prev_q; // Filtered level one cycle back
	logic rise_ev; // Filtered rising edge
	logic fall_ev; // Filtered falling edge
	logic access; // APB access phase
	logic wr_en; // Write strobe
	logic rd_en; // Read strobe
	logic addr_ok; // Address maps to a register
	logic [7:0] rd_byte; // Selected read byte
	logic [1:0] stat_set; // Events this cycle
	pxa_edge_t edge_sel; // Selected edge mode
	logic [2:0] deb_sel; // Selected debounce code

	assign access = psel_in && penable_in;
	assign wr_en = access && pwrite_in && addr_ok && pstrb_in[0];
	assign rd_en = access && !pwrite_in && addr_ok;
	assign edge_sel = pxa_edge_t'(ctrl_q[PXA_CTL_EDGE_HI:PXA_CTL_EDGE_LO]);
	assign deb_sel = ctrl_q[PXA_CTL_DEB_HI:PXA_CTL_DEB_LO];

	// ==========================================================
	// Address decode and read mux
	always_comb begin
		addr_ok = 1'b1;
		rd_byte = 8'h00;
		unique case (paddr_in)
			PXA_OFF_SWC: rd_byte = sw_c_q;
			PXA_OFF_SWD: rd_byte = sw_d_q;
			PXA_OFF_SWE: rd_byte = sw_e_q;
			PXA_OFF_CTRL: rd_byte = ctrl_q;
			PXA_OFF_STAT: rd_byte = {6'h00, stat_q};
			PXA_OFF_MASK: rd_byte = {6'h00, mask_q};
			PXA_OFF_LIVE: rd_byte = {6'h00, filt_q, cmp_gated};
			default: begin
				// Unmapped: error and zero data
				addr_ok = 1'b0;
			end
		endcase
	end

	// APB answer: zero wait states, data and error registered
	always_ff @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			prdata_out <= '0;
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
		end else begin
			pready_out <= psel_in && !penable_in;
			pslverr_out <= psel_in && !penable_in && !addr_ok;
			if (psel_in && !penable_in && !pwrite_in) begin
				prdata_out <= {24'h000000, rd_byte};
			end
		end
	end

	// ==========================================================
	// Switch banks, each bit closes one analog switch
	always_ff @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			sw_c_q <= PXA_RST_BYTE;
			sw_d_q <= PXA_RST_BYTE;
			sw_e_q <= PXA_RST_BYTE;
		end else if (wr_en && pready_out) begin
			if (paddr_in == PXA_OFF_SWC) begin
				sw_c_q <= pwdata_in[7:0];
			end
			if (paddr_in == PXA_OFF_SWD) begin
				sw_d_q <= pwdata_in[7:0];
			end
			if (paddr_in == PXA_OFF_SWE) begin
				sw_e_q <= pwdata_in[7:0];
			end
		end
	end

	// Control and mask registers
	always_ff @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			ctrl_q <= PXA_RST_BYTE;
			mask_q <= PXA_RST_EV;
		end else if (wr_en && pready_out) begin
			if (paddr_in == PXA_OFF_CTRL) begin
				ctrl_q <= pwdata_in[7:0];
			end
			if (paddr_in == PXA_OFF_MASK) begin
				mask_q <= pwdata_in[1:0];
			end
		end
	end

	// ==========================================================
	// Analog control outputs, registered from control bits
	always_ff @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			analog_switch_bits_out <= '0;
			amp1_enable_out <= 1'b0;
			amp1_output_pin_oe_out <= 1'b0;
			amp0_enable_out <= 1'b0;
			amp0_output_pin_oe_out <= 1'b0;
			comparator_dac_enable_out <= 1'b0;
			reference_dac_output_oe_out <= 1'b0;
		end else begin
			analog_switch_bits_out <= {sw_e_q, sw_d_q, sw_c_q};
			amp1_enable_out <= ctrl_q[PXA_CTL_AMP1];
			amp1_output_pin_oe_out <= ctrl_q[PXA_CTL_AMP1];
			amp0_enable_out <= ctrl_q[PXA_CTL_AMP0];
			amp0_output_pin_oe_out <= ctrl_q[PXA_CTL_AMP0];
			comparator_dac_enable_out <= ctrl_q[PXA_CTL_CMP];
			reference_dac_output_oe_out <= ctrl_q[PXA_CTL_CMP];
		end
	end

	// Disabled comparator reads as low
	assign cmp_gated = comparator_raw_out_in && ctrl_q[PXA_CTL_CMP];

	// ==========================================================
	// Debounce filter
	// Required stable periods: code n needs 2^n periods
	always_comb begin
		deb_len = PXA_DEB_ONE << deb_sel;
	end

	// Level accepted once it has differed for deb_len cycles
	always_comb begin
		filt_d = filt_q;
		if (deb_sel == PXA_DEB_BYPASS) begin
			filt_d = cmp_gated;
		end else if (cmp_gated != filt_q && deb_cnt_q + PXA_DEB_ONE >= deb_len) begin
			filt_d = cmp_gated;
		end
	end

	// Counter restarts whenever input agrees with filtered level
	always_ff @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			deb_cnt_q <= '0;
			filt_q <= 1'b0;
		end else begin
			filt_q <= filt_d;
			if (cmp_gated == filt_q || filt_d != filt_q) begin
				deb_cnt_q <= '0;
			end else if (deb_cnt_q != '1) begin
				deb_cnt_q <= deb_cnt_q + PXA_DEB_ONE;
			end
		end
	end

	// ==========================================================
	// Edge detection on filtered level
	always_ff @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			filt_prev_q <= 1'b0;
			comparator_filtered_out <= 1'b0;
		end else begin
			filt_prev_q <= filt_q;
			comparator_filtered_out <= filt_q;
		end
	end

	assign rise_ev = filt_q && !filt_prev_q;
	assign fall_ev = !filt_q && filt_prev_q;

	// Select edges per mode
	always_comb begin
		stat_set = 2'h0;
		unique case (edge_sel)
			PXA_EDGE_NONE: stat_set = 2'h0;
			PXA_EDGE_RISE: stat_set[PXA_ST_RISE] = rise_ev;
			PXA_EDGE_FALL: stat_set[PXA_ST_FALL] = fall_ev;
			PXA_EDGE_BOTH: begin
				stat_set[PXA_ST_RISE] = rise_ev;
				stat_set[PXA_ST_FALL] = fall_ev;
			end
		endcase
	end

	// Sticky status; a read clears, a new event wins over clear
	always_ff @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			stat_q <= PXA_RST_EV;
		end else if (rd_en && pready_out && paddr_in == PXA_OFF_STAT) begin
			stat_q <= stat_set;
		end else begin
			stat_q <= stat_q | stat_set;
		end
	end

	// Level interrupt from unmasked status
	always_ff @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			proximity_interrupt_out <= 1'b0;
		end else begin
			proximity_interrupt_out <= |((stat_q | stat_set) & mask_q);
		end
	end

endmodule

/* pxa_ctrl_sva.sv */
// Assertion checker for the proximity front-end control block.
// Assumes it is bound to pxa_ctrl and sees only that module's ports.
`timescale 1ns/1ps
module pxa_ctrl_sva (
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [pxa_pkg::PXA_DW-1:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	input wire logic comparator_raw_out_in,
	input wire logic [pxa_pkg::PXA_DW-1:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic [23:0] analog_switch_bits_out,
	input wire logic amp1_enable_out,
	input wire logic amp1_output_pin_oe_out,
	input wire logic amp0_enable_out,
	input wire logic amp0_output_pin_oe_out,
	input wire logic comparator_dac_enable_out,
	input wire logic reference_dac_output_oe_out,
	input wire logic comparator_filtered_out,
	input wire logic proximity_interrupt_out
);
	import pxa_pkg::*;
	// ==========================================================
	// Clocking and helpers
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!nrst_in);
	// Accepted write in the access phase
	wire acc_w = psel_in && penable_in && pready_out && pwrite_in && pstrb_in[0];
	// ==========================================================
	// Properties
	property p_rdy; psel_in && !penable_in |=> pready_out; endproperty
	property p_one; pready_out |=> !pready_out; endproperty
	property p_err;
		psel_in && !penable_in && !pwrite_in && paddr_in > PXA_OFF_LIVE
		|=> pslverr_out && prdata_out == 32'h0;
	endproperty
	property p_rdhi; pready_out |-> prdata_out[31:8] == 24'h0; endproperty
	property p_sw;
		acc_w && paddr_in == PXA_OFF_SWC
		|-> ##2 analog_switch_bits_out[7:0] == $past(pwdata_in[7:0], 2);
	endproperty
	property p_ctl;
		acc_w && paddr_in == PXA_OFF_CTRL |-> ##2 {amp1_enable_out,
		amp0_enable_out, comparator_dac_enable_out} == $past(pwdata_in[7:5], 2);
	endproperty
	property p_oe;
		amp1_output_pin_oe_out == amp1_enable_out &&
		amp0_output_pin_oe_out == amp0_enable_out &&
		reference_dac_output_oe_out == comparator_dac_enable_out;
	endproperty
	property p_filt;
		$rose(comparator_filtered_out) |-> $past(comparator_raw_out_in, 2);
	endproperty
	a_rdy: assert property (p_rdy) else $error("no ready");
	a_one: assert property (p_one) else $error("long ready");
	a_err: assert property (p_err) else $error("no error");
	a_rdhi: assert property (p_rdhi) else $error("high bits");
	a_sw: assert property (p_sw) else $error("switch bank");
	a_ctl: assert property (p_ctl) else $error("enables");
	a_oe: assert property (p_oe) else $error("pin drive");
	a_filt: assert property (p_filt) else $error("filter rise");
	c_irq: cover property ($rose(proximity_interrupt_out));
	c_err: cover property (pslverr_out);
	c_filt: cover property ($fell(comparator_filtered_out));
endmodule

bind pxa_ctrl pxa_ctrl_sva pxa_ctrl_sva_i (.*);

/* pxa_ctrl_tb_top.sv */
// Self-checking testbench for the proximity front-end control block.
// Assumes the design answers APB and drives its outputs as registered.
`timescale 1ns/1ps
module pxa_ctrl_tb_top;
	import pxa_pkg::*;
	// ==========================================================
	// Stimulus and observed signals
	logic clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, raw = 0;
	logic [7:0] pa = 8'h00;
	logic [31:0] pwd = 32'h0, rd, prd;
	logic [3:0] pst = 4'hf;
	logic rdy, err, er, filt, irq, a1, a1o, a0, a0o, ce, doe;
	logic [23:0] sw;
	int failures = 0, n_checks = 0;
	// Free-running 100 MHz clock
	always #5 clk = ~clk;
	pxa_ctrl pxa_ctrl_i (.sys_clk_in(clk), .nrst_in(nrst), .psel_in(psel),
		.penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd),
		.pstrb_in(pst), .comparator_raw_out_in(raw), .prdata_out(prd),
		.pready_out(rdy), .pslverr_out(err), .analog_switch_bits_out(sw),
		.amp1_enable_out(a1), .amp1_output_pin_oe_out(a1o),
		.amp0_enable_out(a0), .amp0_output_pin_oe_out(a0o),
		.comparator_dac_enable_out(ce), .reference_dac_output_oe_out(doe),
		.comparator_filtered_out(filt), .proximity_interrupt_out(irq));
	// ==========================================================
	// Shared tasks
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	// One APB transfer; waits for ready under a bound
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (rdy !== 1'b1 && n < 20);
		rd = prd;
		er = err;
		if (n >= 20) failures++;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic x);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
		chk({31'h0, er}, {31'h0, x});
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_rst;
		for (int a = 0; a <= 24; a += 4) rdc(8'(a), 32'h0, 1'b0);
		rdc(8'h1c, 32'h0, 1'b1);
		$display("reset test done");
	endtask
	task automatic t_sw;
		apb(1'b1, PXA_OFF_SWC, 32'ha5);
		apb(1'b1, PXA_OFF_SWD, 32'h3c);
		apb(1'b1, PXA_OFF_SWE, 32'h81);
		pst <= 4'h0;
		apb(1'b1, PXA_OFF_SWC, 32'hff);
		pst <= 4'hf;
		apb(1'b1, 8'h1c, 32'hff);
		chk({31'h0, er}, 32'h1);
		wt(2);
		chk({8'h0, sw}, 32'h813ca5);
		rdc(PXA_OFF_SWD, 32'h3c, 1'b0);
		rdc(PXA_OFF_SWE, 32'h81, 1'b0);
		$display("switch test done");
	endtask
	task automatic t_ctl;
		logic [7:0] v;
		logic [5:0] e;
		for (int i = 5; i < 9; i++) begin
			v = 8'(9'h1 << i);
			e = {v[7], v[7], v[6], v[6], v[5], v[5]};
			apb(1'b1, PXA_OFF_CTRL, {24'h0, v});
			wt(2);
			chk({a1, a1o, a0, a0o, ce, doe}, e);
			rdc(PXA_OFF_CTRL, {24'h0, v}, 1'b0);
		end
		$display("control test done");
	endtask
	task automatic t_edge;
		logic [1:0] m;
		apb(1'b1, PXA_OFF_MASK, 32'h3);
		for (int i = 0; i < 4; i++) begin
			m = 2'(i);
			apb(1'b1, PXA_OFF_CTRL, {24'h0, 3'h1, m, 3'h0});
			raw <= 1'b1;
			wt(8);
			chk(irq, m[0]);
			rdc(PXA_OFF_STAT, {31'h0, m[0]}, 1'b0);
			wt(3);
			chk(irq, 1'b0);
			raw <= 1'b0;
			wt(8);
			chk(irq, m[1]);
			rdc(PXA_OFF_STAT, {30'h0, m[1], 1'b0}, 1'b0);
		end
		apb(1'b1, PXA_OFF_MASK, 32'h0);
		apb(1'b1, PXA_OFF_CTRL, 32'h28);
		raw <= 1'b1;
		wt(8);
		chk(irq, 1'b0);
		rdc(PXA_OFF_STAT, 32'h1, 1'b0);
		raw <= 1'b0;
		wt(8);
		$display("edge test done");
	endtask
	task automatic t_deb;
		apb(1'b1, PXA_OFF_CTRL, 32'h22);
		raw <= 1'b1;
		wt(3);
		raw <= 1'b0;
		wt(8);
		chk(filt, 1'b0);
		raw <= 1'b1;
		wt(3);
		chk(filt, 1'b0);
		wt(7);
		chk(filt, 1'b1);
		rdc(PXA_OFF_LIVE, 32'h3, 1'b0);
		apb(1'b1, PXA_OFF_CTRL, 32'h0);
		wt(8);
		chk(filt, 1'b0);
		raw <= 1'b0;
		$display("debounce test done");
	endtask
	task automatic results;
		$display("checks=%0d failures=%0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// ==========================================================
	// Main sequence and watchdog
	initial begin
		wt(4);
		nrst <= 1'b1;
		wt(1);
		t_rst();
		t_sw();
		t_ctl();
		t_edge();
		t_deb();
		results();
	end
	initial begin
		#100000;
		failures++;
		results();
	end
endmodule
